// [hw/arsf_pkg.sv]
// Package with register map, field positions and timing constants for the receive status flags block.
package arsf_pkg;
  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  // Status register field positions.
  localparam int BIT_RX_FULL = 7;
  localparam int BIT_ADDR_FERR = 6;
  localparam int BIT_OVERRUN = 5;
  // Control register field positions.
  localparam int BIT_EN = 0;
  localparam int BIT_ASYNC = 1;
  localparam int BIT_ADDR_MODE = 2;
  // Interrupt status bit positions.
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_FERR = 2;
  localparam int IRQ_W = 3;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h03;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
  // Line timing: baud rate and system clock rate.
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_HZ = 115200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int HALF_CYCLES = BIT_CYCLES / 2;
  // Receiver state machine.
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } arsf_rx_state_t;
endpackage : arsf_pkg

// [hw/arsf_rx_shift.sv]
// Asynchronous receive shift register: start, data, optional ninth bit, stop.
`timescale 1ns/1ps
module arsf_rx_shift #(
  parameter int BIT_CYC = arsf_pkg::BIT_CYCLES,
  parameter int HALF_CYC = arsf_pkg::HALF_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Configuration.
  input wire logic enable,
  input wire logic ninth_bit,
  // Synchronised serial line.
  input wire logic rxd_sync,
  // Received character.
  output logic start_pulse,
  output logic done_pulse,
  output logic [7:0] data_out,
  output logic addr_out,
  output logic stop_ok
);
  arsf_pkg::arsf_rx_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] idx_reg, idx_next;
  logic [8:0] sh_reg, sh_next;
  logic start_next, done_next, stop_next, stop_reg, start_reg, done_reg;

  // Next-state logic samples each bit at its centre.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    sh_next = sh_reg;
    start_next = 1'b0;
    done_next = 1'b0;
    stop_next = stop_reg;
    unique case (state_reg)
      arsf_pkg::RX_IDLE: begin
        if (enable && !rxd_sync) begin
          state_next = arsf_pkg::RX_START;
          cnt_next = 16'(HALF_CYC);
          start_next = 1'b1;
        end
      end
      arsf_pkg::RX_START: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else if (rxd_sync) begin
          state_next = arsf_pkg::RX_IDLE;
        end else begin
          state_next = arsf_pkg::RX_DATA;
          cnt_next = 16'(BIT_CYC);
          idx_next = 4'h0;
        end
      end
      arsf_pkg::RX_DATA: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          sh_next = {rxd_sync, sh_reg[8:1]};
          cnt_next = 16'(BIT_CYC);
          idx_next = idx_reg + 4'h1;
          if (idx_reg == (ninth_bit ? 4'h8 : 4'h7)) begin
            state_next = arsf_pkg::RX_STOP;
          end
        end
      end
      arsf_pkg::RX_STOP: begin
        if (cnt_reg != 16'h0000) begin
          cnt_next = cnt_reg - 16'h0001;
        end else begin
          if (!ninth_bit) begin
            sh_next = {1'b0, sh_reg[8:1]};
          end
          stop_next = rxd_sync;
          done_next = 1'b1;
          state_next = arsf_pkg::RX_IDLE;
        end
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= arsf_pkg::RX_IDLE;
      cnt_reg <= 16'h0000;
      idx_reg <= 4'h0;
      sh_reg <= 9'h000;
      start_reg <= 1'b0;
      done_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      sh_reg <= sh_next;
      start_reg <= start_next;
      done_reg <= done_next;
      stop_reg <= stop_next;
    end
  end

  assign start_pulse = start_reg;
  assign done_pulse = done_reg;
  assign data_out = sh_reg[7:0];
  assign addr_out = sh_reg[8];
  assign stop_ok = stop_reg;
endmodule : arsf_rx_shift

// [hw/arsf_top.sv]
// Receive status flags block of an asynchronous serial port with an APB register slave.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module arsf_top #(
  parameter int BIT_CYC = arsf_pkg::BIT_CYCLES,
  parameter int HALF_CYC = arsf_pkg::HALF_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line and interrupt.
  input wire logic rxd,
  output logic irq,
  output logic rx_irq_ff
);
  logic rxd_meta_reg, rxd_sync_reg;
  logic shift_start, shift_done, shift_addr, shift_stop;
  logic [7:0] shift_data;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] data_reg, data_next;
  logic full_reg, full_next;
  logic flag6_reg, flag6_next;
  logic ovr_reg, ovr_next;
  logic pend_reg, pend_next;
  logic [7:0] pend_data_reg, pend_data_next;
  logic pend_flag_reg, pend_flag_next;
  logic rxirq_reg, rxirq_next;
  logic [arsf_pkg::IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  logic async_mode, addr_mode, acc, rd_data, rd_ist;
  logic [7:0] status_byte;

  // Decides whether an offset is a mapped register.
  function automatic logic arsf_mapped(input logic [7:0] a);
    return a == arsf_pkg::ADDR_DATA || a == arsf_pkg::ADDR_STATUS || a == arsf_pkg::ADDR_CTRL ||
           a == arsf_pkg::ADDR_IRQ_STAT || a == arsf_pkg::ADDR_IRQ_MASK;
  endfunction : arsf_mapped

  // Two-stage synchroniser for the serial input.
  // Only the second stage feeds logic, so a metastable first stage never spreads.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // Shift register receiver.
  arsf_rx_shift #(
    .BIT_CYC(BIT_CYC),
    .HALF_CYC(HALF_CYC)
  ) u_shift (
    .clk(clk),
    .resetn(resetn),
    .enable(ctrl_reg[arsf_pkg::BIT_EN]),
    .ninth_bit(addr_mode),
    .rxd_sync(rxd_sync_reg),
    .start_pulse(shift_start),
    .done_pulse(shift_done),
    .data_out(shift_data),
    .addr_out(shift_addr),
    .stop_ok(shift_stop)
  );

  // Bus decode; the access phase takes two cycles, since pready is registered.
  // A transfer is taken once, in the access cycle before pready rises.
  assign async_mode = ctrl_reg[arsf_pkg::BIT_ASYNC];
  assign addr_mode = ctrl_reg[arsf_pkg::BIT_ADDR_MODE];
  assign acc = psel && penable && !pready_reg;
  assign rd_data = acc && !pwrite && paddr == arsf_pkg::ADDR_DATA;
  assign rd_ist = acc && !pwrite && paddr == arsf_pkg::ADDR_IRQ_STAT;

  // Status byte seen by software; zero outside asynchronous mode.
  // Other modes give these positions other meanings, so the flags are hidden there.
  always_comb begin
    status_byte = 8'h00;
    if (async_mode) begin
      status_byte[arsf_pkg::BIT_RX_FULL] = full_reg;
      status_byte[arsf_pkg::BIT_ADDR_FERR] = flag6_reg;
      status_byte[arsf_pkg::BIT_OVERRUN] = ovr_reg;
    end
  end

  // Receive data path, flags and receiver interrupt flip-flop.
  always_comb begin
    data_next = data_reg;
    full_next = full_reg;
    flag6_next = flag6_reg;
    ovr_next = ovr_reg;
    pend_next = pend_reg;
    pend_data_next = pend_data_reg;
    pend_flag_next = pend_flag_reg;
    rxirq_next = rxirq_reg;
    // A data read empties the buffer and clears the flags and the receiver interrupt.
    if (rd_data) begin
      full_next = 1'b0;
      flag6_next = 1'b0;
      ovr_next = 1'b0;
      rxirq_next = 1'b0;
    end
    // A waiting character moves into the data register in the same cycle.
    if (rd_data && pend_reg) begin
      data_next = pend_data_reg;
      flag6_next = pend_flag_reg;
      full_next = 1'b1;
      pend_next = 1'b0;
    end
    // A finished character fills the data register if free, else the waiting slot.
    if (shift_done) begin
      if (!full_next) begin
        data_next = shift_data;
        flag6_next = addr_mode ? shift_addr : !shift_stop;
        full_next = 1'b1;
      end else begin
        pend_data_next = shift_data;
        pend_flag_next = addr_mode ? shift_addr : !shift_stop;
        pend_next = 1'b1;
      end
    end
    // A start bit while both stages are occupied is an overrun; the newer character replaces the waiting one.
    if (shift_start && full_reg && pend_reg) begin
      ovr_next = 1'b1;
    end
    // Setting after the clears lets a reload raise the interrupt again in the same cycle.
    if (full_next && !full_reg) begin
      rxirq_next = 1'b1;
    end
    if (full_next && rd_data) begin
      rxirq_next = 1'b1;
    end
  end

  // Control, interrupt and bus answer next values.
  always_comb begin
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    ist_next = ist_reg;
    prdata_next = 32'h0000_0000;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (rd_ist) begin
      ist_next = '0;
    end
    if (acc) begin
      pready_next = 1'b1;
      pslverr_next = !arsf_mapped(paddr);
      // Only the control and mask registers take writes; other offsets ignore them.
      if (pwrite) begin
        if (paddr == arsf_pkg::ADDR_CTRL) begin
          ctrl_next = pwdata[7:0];
        end
        if (paddr == arsf_pkg::ADDR_IRQ_MASK) begin
          imask_next = pwdata[arsf_pkg::IRQ_W-1:0];
        end
      end else begin
        unique case (paddr)
          arsf_pkg::ADDR_DATA: prdata_next = {24'h000000, data_reg};
          arsf_pkg::ADDR_STATUS: prdata_next = {24'h000000, status_byte};
          arsf_pkg::ADDR_CTRL: prdata_next = {24'h000000, ctrl_reg};
          arsf_pkg::ADDR_IRQ_STAT: prdata_next = {29'h0000000, ist_reg};
          arsf_pkg::ADDR_IRQ_MASK: prdata_next = {29'h0000000, imask_reg};
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
    // Events set sticky bits; a set in the clearing cycle wins.
    if (full_next && !full_reg) begin
      ist_next[arsf_pkg::IRQ_RX] = 1'b1;
    end
    if (ovr_next && !ovr_reg) begin
      ist_next[arsf_pkg::IRQ_OVR] = 1'b1;
    end
    if (flag6_next && !flag6_reg) begin
      ist_next[arsf_pkg::IRQ_FERR] = 1'b1;
    end
    irq_next = |(ist_next & imask_next);
  end

  // Registers for all state groups except the two synchroniser stages.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= arsf_pkg::CTRL_RESET;
      data_reg <= 8'h00;
      full_reg <= 1'b0;
      flag6_reg <= 1'b0;
      ovr_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_data_reg <= 8'h00;
      pend_flag_reg <= 1'b0;
      rxirq_reg <= 1'b0;
      ist_reg <= '0;
      imask_reg <= arsf_pkg::MASK_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      data_reg <= data_next;
      full_reg <= full_next;
      flag6_reg <= flag6_next;
      ovr_reg <= ovr_next;
      pend_reg <= pend_next;
      pend_data_reg <= pend_data_next;
      pend_flag_reg <= pend_flag_next;
      rxirq_reg <= rxirq_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign rx_irq_ff = rxirq_reg;

  // Data read while a second character waits and no new one lands.
  sequence s_reload_read;
    rd_data && pend_reg && !shift_done;
  endsequence

  // Buffer still full, interrupt flip-flop set and the waiting slot emptied.
  sequence s_reload_done;
    full_reg && rxirq_reg && !pend_reg;
  endsequence

  // Access phase taken by the slave.
  sequence s_bus_take;
    acc;
  endsequence

  // Answer that stands for exactly one cycle.
  sequence s_bus_answer;
    pready_reg ##1 !pready_reg;
  endsequence

  // A data read empties the buffer unless a waiting character or one finishing in the same cycle reloads it.
  a_read_clears: assert property (@(posedge clk) disable iff (!resetn)
    rd_data && !pend_reg && !shift_done |=> !full_reg && !ovr_reg)
    else $error("data read did not clear flags");

  // Full rising raises the receiver interrupt flip-flop.
  a_full_sets_irq: assert property (@(posedge clk) disable iff (!resetn)
    $rose(full_reg) |-> rxirq_reg)
    else $error("interrupt flip-flop not set by full");

  // Read with a pending character keeps buffer full and interrupt set.
  a_reload_next: assert property (@(posedge clk) disable iff (!resetn)
    s_reload_read |=> s_reload_done)
    else $error("pending character not reloaded");

  // Plain read empties and clears interrupt.
  a_read_clr_irq: assert property (@(posedge clk) disable iff (!resetn)
    rd_data && !pend_reg && !shift_done |=> !rxirq_reg)
    else $error("interrupt flip-flop not cleared");

  // Only a data read lowers the receiver interrupt flip-flop.
  a_irq_ff_clear: assert property (@(posedge clk) disable iff (!resetn)
    $fell(rxirq_reg) |-> $past(rd_data))
    else $error("interrupt flip-flop fell without a read");

  // Start bit while both stages full raises overrun.
  a_overrun_set: assert property (@(posedge clk) disable iff (!resetn)
    shift_start && full_reg && pend_reg && !rd_data |=> ovr_reg)
    else $error("overrun not flagged");

  // The overrun flag stays set until a data read.
  a_ovr_sticky: assert property (@(posedge clk) disable iff (!resetn)
    ovr_reg && !rd_data |=> ovr_reg)
    else $error("overrun flag lost");

  // Status bit 7 mirrors buffer full in async mode.
  a_status_full: assert property (@(posedge clk) disable iff (!resetn)
    acc && !pwrite && paddr == arsf_pkg::ADDR_STATUS && async_mode |=>
      prdata_reg[arsf_pkg::BIT_RX_FULL] == $past(full_reg))
    else $error("status bit 7 wrong");

  // Good stop in data mode loads a clean flag.
  a_stop_flag: assert property (@(posedge clk) disable iff (!resetn)
    shift_done && !full_reg && !pend_reg && !addr_mode && !rd_data |=> flag6_reg == !$past(shift_stop))
    else $error("framing flag wrong");

  // Address mode loads the ninth bit as flag.
  a_addr_flag: assert property (@(posedge clk) disable iff (!resetn)
    shift_done && !full_reg && !pend_reg && addr_mode && !rd_data |=> flag6_reg == $past(shift_addr))
    else $error("address flag wrong");

  // Outside async mode the status flags read zero.
  a_mode_gate: assert property (@(posedge clk) disable iff (!resetn)
    acc && !pwrite && paddr == arsf_pkg::ADDR_STATUS && !async_mode |=> prdata_reg[7:0] == 8'h00)
    else $error("status not zero outside async");

  // A rising buffer-full flag is recorded in the interrupt status.
  a_ist_rx_set: assert property (@(posedge clk) disable iff (!resetn)
    $rose(full_reg) |-> ist_reg[arsf_pkg::IRQ_RX])
    else $error("receive event not recorded");

  // The interrupt output follows the unmasked sticky bits.
  a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    irq_reg == |(ist_reg & imask_reg))
    else $error("interrupt output out of step");

  // Every taken access is answered by a single ready pulse.
  a_bus_answer: assert property (@(posedge clk) disable iff (!resetn)
    s_bus_take |=> s_bus_answer)
    else $error("bus answer not a single pulse");

  // An unmapped offset answers with an error.
  a_unmapped_err: assert property (@(posedge clk) disable iff (!resetn)
    acc && !arsf_mapped(paddr) |=> pready_reg && pslverr_reg)
    else $error("unmapped access not refused");
endmodule : arsf_top

// [verification/arsf_tx_model.sv]
// Behavioural model of the remote asynchronous transmitter on the receive line.
`timescale 1ns/1ps
module arsf_tx_model #(
  parameter int BIT_CYC = 8
) (
  // Clock.
  input wire logic clk,
  // Serial line, idle high.
  output logic rxd
);
  // The line rests at its idle level between frames.
  initial begin
    rxd = 1'b1;
  end

  // Sends one frame LSB first, each bit BIT_CYC+1 cycles; a low stop level makes a framing error.
  task automatic send(input logic [7:0] d, input logic nine_en, input logic nine, input logic stop);
    logic [10:0] frame;
    int n;
    frame = nine_en ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = nine_en ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd <= frame[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask : send
endmodule : arsf_tx_model

// [verification/async_rx_status_flags_tb_top.sv]
// Self-checking testbench for the receive status flags block.
`timescale 1ns/1ps
module async_rx_status_flags_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic rxd;
  logic irq;
  logic rx_irq_ff;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int comparisons = 0;

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  arsf_top #(.BIT_CYC(8), .HALF_CYC(4)) dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .irq(irq), .rx_irq_ff(rx_irq_ff));
  arsf_tx_model #(.BIT_CYC(8)) txm (.clk(clk), .rxd(rxd));

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    bit done;
    done = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        done = 1;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      print_verdict();
    end
  endtask : apb

  // Reads a register and compares it with the expected word.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk

  // Sends a plain character and lets the synchroniser and stop sampling finish.
  task automatic rx_char(input logic [7:0] d, input logic stop);
    txm.send(d, 1'b0, 1'b0, stop);
    repeat (4) @(posedge clk);
  endtask : rx_char

  // Reset values, ignored status write and an unmapped address.
  task automatic t_reset();
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, rx_irq_ff}, 32'h0);
    apb(1'b1, arsf_pkg::ADDR_STATUS, 32'h0000_00FF);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_0000);
    rd_chk(arsf_pkg::ADDR_CTRL, 32'h0000_0003);
    rd_chk(arsf_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  // A good character sets full and the interrupt flip-flop; the data read clears both.
  task automatic t_plain();
    rx_char(8'hA5, 1'b1);
    chk({31'h0, rx_irq_ff}, 32'h1);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_0080);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_00A5);
    repeat (2) @(posedge clk);
    chk({31'h0, rx_irq_ff}, 32'h0);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_0000);
    rd_chk(arsf_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    $display("test plain done");
  endtask : t_plain

  // An all-zero byte with a low stop bit is a break and shows the framing flag.
  task automatic t_break();
    rx_char(8'h00, 1'b0);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_00C0);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_0000);
    rd_chk(arsf_pkg::ADDR_IRQ_STAT, 32'h0000_0005);
    $display("test break done");
  endtask : t_break

  // Address character then data character back to back; the read reloads the next one.
  task automatic t_addr();
    apb(1'b1, arsf_pkg::ADDR_CTRL, 32'h0000_0007);
    txm.send(8'h11, 1'b1, 1'b1, 1'b1);
    txm.send(8'h22, 1'b1, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_00C0);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_0011);
    repeat (3) @(posedge clk);
    chk({31'h0, rx_irq_ff}, 32'h1);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_0080);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_0022);
    rd_chk(arsf_pkg::ADDR_IRQ_STAT, 32'h0000_0005);
    apb(1'b1, arsf_pkg::ADDR_CTRL, 32'h0000_0003);
    $display("test address done");
  endtask : t_addr

  // Three characters without a read overrun the receiver; the data read clears it.
  task automatic t_overrun();
    txm.send(8'h31, 1'b0, 1'b0, 1'b1);
    txm.send(8'h32, 1'b0, 1'b0, 1'b1);
    rx_char(8'h33, 1'b1);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_00A0);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_0031);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_0080);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_0033);
    rd_chk(arsf_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    $display("test overrun done");
  endtask : t_overrun

  // Unmasked event raises irq, reading the interrupt status lowers it, a masked one stays quiet.
  task automatic t_irq();
    apb(1'b1, arsf_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    rd_chk(arsf_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    rx_char(8'h5A, 1'b1);
    chk({31'h0, irq}, 32'h1);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_005A);
    rd_chk(arsf_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, arsf_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    rx_char(8'h00, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd_chk(arsf_pkg::ADDR_DATA, 32'h0000_0000);
    rd_chk(arsf_pkg::ADDR_IRQ_STAT, 32'h0000_0005);
    $display("test interrupt done");
  endtask : t_irq

  // Outside asynchronous mode the receive flags read zero.
  task automatic t_mode();
    apb(1'b1, arsf_pkg::ADDR_CTRL, 32'h0000_0001);
    rx_char(8'h00, 1'b0);
    rd_chk(arsf_pkg::ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, arsf_pkg::ADDR_CTRL, 32'h0000_0003);
    $display("test mode done");
  endtask : t_mode

  // Main sequence: reset for three cycles, then every scenario.
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_plain();
    t_break();
    t_addr();
    t_overrun();
    t_irq();
    t_mode();
    print_verdict();
  end
endmodule : async_rx_status_flags_tb_top
